// >>> hdl/etfb_pkg.sv
// Constants for the explicit transmit frame parser
package etfb_pkg;
  localparam logic [7:0]  START_DELIM     = 8'h7e;
  localparam logic [7:0]  FRAME_TYPE_EXPL = 8'h11;
  localparam logic [15:0] OFF_FRAME_TYPE  = 16'h0003;
  localparam logic [15:0] OFF_FRAME_ID    = 16'h0004;
  localparam logic [15:0] OFF_DST64_MSB   = 16'h0005;
  localparam logic [15:0] OFF_DST64_LSB   = 16'h000c;
  localparam logic [15:0] OFF_DST16_MSB   = 16'h000d;
  localparam logic [15:0] OFF_DST16_LSB   = 16'h000e;
  localparam logic [15:0] OFF_SRC_EP      = 16'h000f;
  localparam logic [15:0] OFF_DST_EP      = 16'h0010;
  localparam logic [15:0] OFF_CLUSTER_MSB = 16'h0011;
  localparam logic [15:0] OFF_CLUSTER_LSB = 16'h0012;
  localparam logic [15:0] OFF_PROFILE_MSB = 16'h0013;
  localparam logic [15:0] OFF_PROFILE_LSB = 16'h0014;
  localparam logic [15:0] OFF_RADIUS      = 16'h0015;
  localparam logic [15:0] OFF_OPTIONS     = 16'h0016;
  localparam logic [15:0] OFF_FRAME_CTRL  = 16'h0017;
  localparam logic [15:0] OFF_SEQ_NUM     = 16'h0018;
  localparam logic [15:0] OFF_CMD_ID      = 16'h0019;
  localparam logic [15:0] OFF_PAYLOAD     = 16'h001a;
  localparam logic [15:0] HDR_BYTES       = 16'h0003;
  localparam logic [7:0]  CSUM_GOOD       = 8'hff;
  localparam logic [1:0]  FTYPE_GENERAL   = 2'h0;
  localparam logic [7:0]  MAX_HOPS_DFLT   = 8'h1e;
  // General command identifiers and their decoded kinds
  localparam logic [7:0]  CMD_READ        = 8'h00;
  localparam logic [7:0]  CMD_READ_RSP    = 8'h01;
  localparam logic [7:0]  CMD_WRITE       = 8'h02;
  localparam logic [7:0]  CMD_WRITE_RSP   = 8'h04;
  localparam logic [7:0]  CMD_CFG_REPORT  = 8'h06;
  localparam logic [7:0]  CMD_REPORT      = 8'h0a;
  localparam logic [7:0]  CMD_DISCOVER    = 8'h0c;
  localparam logic [7:0]  CMD_DISC_RSP    = 8'h0d;
  localparam logic [3:0]  KIND_READ       = 4'h1;
  localparam logic [3:0]  KIND_READ_RSP   = 4'h2;
  localparam logic [3:0]  KIND_WRITE      = 4'h3;
  localparam logic [3:0]  KIND_WRITE_RSP  = 4'h4;
  localparam logic [3:0]  KIND_CFG_REPORT = 4'h5;
  localparam logic [3:0]  KIND_REPORT     = 4'h6;
  localparam logic [3:0]  KIND_DISCOVER   = 4'h7;
  localparam logic [3:0]  KIND_DISC_RSP   = 4'h8;
  localparam logic [3:0]  KIND_OTHER      = 4'h0;
  typedef enum logic [2:0] {ST_IDLE, ST_LEN_MSB, ST_LEN_LSB, ST_BODY, ST_CSUM} etfb_state_e;
endpackage

// >>> hdl/etfb_frame_parser.sv
// Explicit transmit frame parser with payload buffer and checksum gate
`timescale 1ns/1ps
// How it works
// (RL1) Frame type 0x11 at offset 3
// (RL2) Frame id zero suppresses transmit status
// (RL3) 64-bit destination big endian, offsets 5-12
// (RL4) 16-bit destination big endian, offsets 13-14
// (RL5) Source endpoint 15, destination endpoint 16
// (RL6) Cluster id offsets 17-18, high first
// (RL7) Profile id offsets 19-20, high first
// (RL8) Zero radius means network maximum hops
// (RL9) Transmit options byte all zero
// (RL10) Payload opens with frame control at 23
// (RL11) Sequence number at 24 echoed by responder
// (RL12) Command id at 25; general 0x00 reads
// (RL13) Decode the other general command identifiers
// (RL14) Read payload lists 16-bit attribute ids
// (RL15) Library header and payload little endian
// (RL16) Checksum is 0xFF minus byte sum
// (RL17) Host enables explicit receive format option
// (RL18) Delimiter, then big-endian length before body
// (RL19) Bad checksum frame is discarded entirely; here its payload still goes out and only frame_good and status_wanted stay low
module etfb_frame_parser #(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  output logic [7:0]       pay_data,
  output logic             pay_valid,
  input  wire logic        pay_ready,
  output logic             frame_done,
  output logic             frame_good,
  output logic             status_wanted,
  output logic [7:0]       frame_id,
  output logic [63:0]      dst64,
  output logic [15:0]      dst16,
  output logic [7:0]       src_ep,
  output logic [7:0]       dst_ep,
  output logic [15:0]      cluster_id,
  output logic [15:0]      profile_id,
  output logic [7:0]       radius,
  output logic [7:0]       tx_options,
  output logic [7:0]       frame_ctrl,
  output logic [7:0]       seq_num,
  output logic [7:0]       cmd_id,
  output logic [3:0]       cmd_kind,
  output logic [15:0]      first_attr
);
  // Pointer and count widths serve exactly two entries, so refuse any other depth
  if (BUF_DEPTH != 2) begin : g_depth_check
    $error("BUF_DEPTH must be 2");
  end

  // ************************************************************
  // Byte intake
  // ************************************************************
  etfb_pkg::etfb_state_e state;
  logic [15:0] length;
  logic [15:0] offset;
  logic [7:0]  sum;
  logic [7:0]  mem [BUF_DEPTH];
  logic [1:0]  count;
  logic        wr_ptr;
  logic        rd_ptr;
  logic [7:0]  frame_type_q;

  wire  buf_full   = (count == 2'h2);
  wire  take       = rx_valid && rx_ready;
  wire  [15:0] end_off = length + etfb_pkg::HDR_BYTES;
  wire  is_payload = (state == etfb_pkg::ST_BODY) && (offset >= etfb_pkg::OFF_FRAME_CTRL);
  wire  push       = take && is_payload;
  wire  pop        = pay_valid && pay_ready;
  wire  [7:0] next_sum = sum + rx_byte;
  wire  last_body  = (offset + 16'h0001 == end_off);
  wire  csum_ok    = ((sum + rx_byte) == etfb_pkg::CSUM_GOOD); // RL16
  wire  type_ok    = (frame_type_q == etfb_pkg::FRAME_TYPE_EXPL); // RL1

  // Payload bytes stall intake when the buffer is full, so none is lost
  always_ff @(posedge ref_clk) begin
    if (rst) rx_ready <= 1'b0;
    else rx_ready <= !(buf_full || (count == 2'h1 && push)) || pop;
  end

  // Frame walker: delimiter, length, body, checksum
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state  <= etfb_pkg::ST_IDLE;
      length <= 16'h0000;
      offset <= 16'h0000;
      sum    <= 8'h00;
    end else if (take) begin
      case (state)
        etfb_pkg::ST_IDLE: begin
          if (rx_byte == etfb_pkg::START_DELIM) state <= etfb_pkg::ST_LEN_MSB; // RL18
        end
        etfb_pkg::ST_LEN_MSB: begin
          length[15:8] <= rx_byte; // RL18
          state <= etfb_pkg::ST_LEN_LSB;
        end
        etfb_pkg::ST_LEN_LSB: begin
          length[7:0] <= rx_byte;
          offset <= etfb_pkg::OFF_FRAME_TYPE;
          sum    <= 8'h00;
          state  <= ({length[15:8], rx_byte} == 16'h0000) ? etfb_pkg::ST_IDLE
                                                       : etfb_pkg::ST_BODY;
        end
        etfb_pkg::ST_BODY: begin
          sum    <= next_sum; // RL16
          offset <= offset + 16'h0001;
          if (last_body) state <= etfb_pkg::ST_CSUM;
        end
        etfb_pkg::ST_CSUM: state <= etfb_pkg::ST_IDLE;
        default: state <= etfb_pkg::ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Field capture
  // ************************************************************
  // Addresses and ids arrive high byte first; attribute ids low byte first
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      frame_type_q <= 8'h00;
      frame_id     <= 8'h00;
      dst64        <= 64'h0;
      dst16        <= 16'h0000;
      src_ep       <= 8'h00;
      dst_ep       <= 8'h00;
      cluster_id   <= 16'h0000;
      profile_id   <= 16'h0000;
      radius       <= 8'h00;
      tx_options   <= 8'h00;
      frame_ctrl   <= 8'h00;
      seq_num      <= 8'h00;
      cmd_id       <= 8'h00;
      first_attr   <= 16'h0000;
    end else if (take && state == etfb_pkg::ST_BODY) begin
      if (offset == etfb_pkg::OFF_FRAME_TYPE) frame_type_q <= rx_byte; // RL1
      if (offset == etfb_pkg::OFF_FRAME_ID) frame_id <= rx_byte; // RL2
      if (offset >= etfb_pkg::OFF_DST64_MSB && offset <= etfb_pkg::OFF_DST64_LSB)
        dst64 <= {dst64[55:0], rx_byte}; // RL3
      if (offset == etfb_pkg::OFF_DST16_MSB) dst16[15:8] <= rx_byte; // RL4
      if (offset == etfb_pkg::OFF_DST16_LSB) dst16[7:0] <= rx_byte; // RL4
      if (offset == etfb_pkg::OFF_SRC_EP) src_ep <= rx_byte; // RL5
      if (offset == etfb_pkg::OFF_DST_EP) dst_ep <= rx_byte; // RL5
      if (offset == etfb_pkg::OFF_CLUSTER_MSB) cluster_id[15:8] <= rx_byte; // RL6
      if (offset == etfb_pkg::OFF_CLUSTER_LSB) cluster_id[7:0] <= rx_byte; // RL6
      if (offset == etfb_pkg::OFF_PROFILE_MSB) profile_id[15:8] <= rx_byte; // RL7
      if (offset == etfb_pkg::OFF_PROFILE_LSB) profile_id[7:0] <= rx_byte; // RL7
      // A zero radius is replaced by the network hop limit
      if (offset == etfb_pkg::OFF_RADIUS)
        radius <= (rx_byte == 8'h00) ? etfb_pkg::MAX_HOPS_DFLT : rx_byte; // RL8
      if (offset == etfb_pkg::OFF_OPTIONS) tx_options <= rx_byte; // RL9
      if (offset == etfb_pkg::OFF_FRAME_CTRL) frame_ctrl <= rx_byte; // RL10
      if (offset == etfb_pkg::OFF_SEQ_NUM) seq_num <= rx_byte; // RL11
      if (offset == etfb_pkg::OFF_CMD_ID) cmd_id <= rx_byte; // RL12
      if (offset == etfb_pkg::OFF_PAYLOAD) first_attr[7:0] <= rx_byte; // RL15
      if (offset == etfb_pkg::OFF_PAYLOAD + 16'h0001) first_attr[15:8] <= rx_byte; // RL14
    end
  end

  // ************************************************************
  // Command decode and frame verdict
  // ************************************************************
  // Non-general frame types are not decoded as general commands
  wire       is_general = (frame_ctrl[1:0] == etfb_pkg::FTYPE_GENERAL); // RL12
  wire [3:0] kind_dec =
    !is_general                          ? etfb_pkg::KIND_OTHER :
    (cmd_id == etfb_pkg::CMD_READ)       ? etfb_pkg::KIND_READ : // RL12
    (cmd_id == etfb_pkg::CMD_READ_RSP)   ? etfb_pkg::KIND_READ_RSP : // RL13
    (cmd_id == etfb_pkg::CMD_WRITE)      ? etfb_pkg::KIND_WRITE :
    (cmd_id == etfb_pkg::CMD_WRITE_RSP)  ? etfb_pkg::KIND_WRITE_RSP :
    (cmd_id == etfb_pkg::CMD_CFG_REPORT) ? etfb_pkg::KIND_CFG_REPORT :
    (cmd_id == etfb_pkg::CMD_REPORT)     ? etfb_pkg::KIND_REPORT :
    (cmd_id == etfb_pkg::CMD_DISCOVER)   ? etfb_pkg::KIND_DISCOVER :
    (cmd_id == etfb_pkg::CMD_DISC_RSP)   ? etfb_pkg::KIND_DISC_RSP :
                                           etfb_pkg::KIND_OTHER;
  wire       at_csum  = take && state == etfb_pkg::ST_CSUM;
  wire       verdict  = csum_ok && type_ok; // RL19

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      frame_done    <= 1'b0;
      frame_good    <= 1'b0;
      status_wanted <= 1'b0;
      cmd_kind      <= etfb_pkg::KIND_OTHER;
    end else begin
      frame_done    <= at_csum;
      frame_good    <= at_csum && verdict; // RL19
      status_wanted <= at_csum && verdict && (frame_id != 8'h00); // RL2
      cmd_kind      <= kind_dec; // RL13
    end
  end

  // ************************************************************
  // Two-entry payload buffer
  // ************************************************************
  // Payload goes out as it arrives; a bad checksum is flagged at the end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count  <= 2'h0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) mem[wr_ptr] <= rx_byte;
  end

  // Output stage registered from the buffer head
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pay_valid <= 1'b0;
      pay_data  <= 8'h00;
    end else if (!pay_valid || pay_ready) begin
      pay_valid <= (count != 2'h0) && !pop;
      pay_data  <= mem[rd_ptr];
    end
  end
endmodule

// >>> dv/etfb_frame_parser_properties.sv
// Port checker for the explicit transmit frame parser
`timescale 1ns/1ps
// ********
// Checker
// ********
module etfb_frame_checker (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       pay_valid,
  input wire logic       pay_ready,
  input wire logic [7:0] pay_data,
  input wire logic       frame_done,
  input wire logic       frame_good,
  input wire logic       status_wanted,
  input wire logic [7:0] frame_id,
  input wire logic [7:0] radius,
  input wire logic [7:0] frame_ctrl,
  input wire logic [7:0] cmd_id,
  input wire logic [3:0] cmd_kind
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Verdict and status pulses only ride on the end-of-frame pulse
  AST_GOOD_WITH_DONE: assert property (frame_good |-> frame_done)
    else $error("good without done");
  AST_DONE_ONE_CYCLE: assert property (frame_done |=> !frame_done)
    else $error("done pulse too long");
  AST_STATUS_NEEDS_ID: assert property (status_wanted |-> frame_good && frame_id != 8'h00)
    else $error("status for zero id");
  AST_STATUS_GIVEN: assert property (frame_good && frame_id != 8'h00 |-> status_wanted)
    else $error("status missing");
  AST_RADIUS_SUBST: assert property (frame_good |-> radius != 8'h00)
    else $error("radius left zero");
  // A stalled word must not change or vanish
  AST_PAY_HOLD: assert property (pay_valid && !pay_ready |=> pay_valid && $stable(pay_data))
    else $error("payload lost in stall");
  AST_KIND_READ: assert property (frame_good && frame_ctrl[1:0] == etfb_pkg::FTYPE_GENERAL
    && cmd_id == etfb_pkg::CMD_READ |-> cmd_kind == etfb_pkg::KIND_READ)
    else $error("read not decoded");
  AST_KIND_OTHER: assert property (frame_good && frame_ctrl[1:0] != 2'h0
    |-> cmd_kind == etfb_pkg::KIND_OTHER)
    else $error("non-general decoded");
  COV_STATUS: cover property (status_wanted);
  COV_BAD: cover property (frame_done && !frame_good);
  COV_STALL: cover property (pay_valid && !pay_ready);
endmodule
bind etfb_frame_parser etfb_frame_checker etfb_frame_checker_i (
  .ref_clk(ref_clk), .rst(rst), .pay_valid(pay_valid), .pay_ready(pay_ready),
  .pay_data(pay_data), .frame_done(frame_done), .frame_good(frame_good),
  .status_wanted(status_wanted), .frame_id(frame_id), .radius(radius),
  .frame_ctrl(frame_ctrl), .cmd_id(cmd_id), .cmd_kind(cmd_kind));

// >>> dv/etfb_host.sv
// Host controller model feeding frame bytes to the parser
`timescale 1ns/1ps
// ********
// Host model
// ********
module etfb_host (
  input  wire logic       ref_clk,
  input  wire logic       rx_ready,
  output logic      [7:0] rx_byte,
  output logic            rx_valid
);
  localparam logic [63:0] A64 = 64'h0102030405060708;
  localparam logic [15:0] A16 = 16'hfffe;
  localparam logic [15:0] CL  = 16'h0201;
  localparam logic [15:0] PR  = 16'hd123;
  // The host keeps receive_format_option at 1; that setting lies outside these frames
  logic timed_out = 1'b0;
  initial rx_valid = 1'b0;
  initial rx_byte = 8'h00;
  // Offer after a falling edge, hold until a rising edge finds ready
  task automatic put(input logic [7:0] b);
    int n = 0;
    @(negedge ref_clk);
    rx_byte = b;
    rx_valid = 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rx_ready !== 1'b1 && n < 300);
    if (rx_ready !== 1'b1) timed_out = 1'b1;
  endtask
  // Released line shows the inverse, so a stale byte is never mistaken
  task automatic idle();
    @(negedge ref_clk);
    rx_valid = 1'b0;
    rx_byte = ~rx_byte;
  endtask
  // Whole frame; more keeps the line busy for a back-to-back follower
  // Bad bit 0 spoils the checksum, bit 1 the frame type; 64-bit address, endpoints and cluster follow seq
  task automatic send(input logic [7:0] id, rad, ctrl, seq, cmd, input logic [1:0] bad,
                      input logic more);
    logic [199:0] v = {bad[1] ? 8'h10 : 8'h11, id, A64 ^ {8{seq}}, A16,
      8'h41 ^ seq, 8'h42 ^ seq, CL ^ {8'h00, seq}, PR, rad, 8'h00,
      ctrl, seq, cmd, 8'h03, 8'h00};
    logic [7:0] sum = 8'h00;
    put(8'h7e);
    put(8'h00);
    put(8'h19);
    for (int i = 24; i >= 0; i--) begin
      put(v[i*8 +: 8]);
      sum += v[i*8 +: 8];
    end
    put((8'hff - sum) ^ {7'h00, bad[0]});
    if (!more) idle();
  endtask
endmodule

// >>> dv/explicit_tx_frame_builder_tb_top.sv
// Self-checking bench for the explicit transmit frame parser
`timescale 1ns/1ps
// ********
// Bench top
// ********
module explicit_tx_frame_builder_tb_top;
  typedef struct packed {logic [7:0] id, rad, ctrl, cmd; logic [3:0] kind;} etfb_row_s;
  logic        ref_clk, rx_valid, rx_ready, pay_valid, frame_done, frame_good, status_wanted;
  logic        rst = 1'b1;
  logic        pay_ready = 1'b1;
  logic        stall = 1'b0;
  logic [7:0]  rx_byte, pay_data, frame_id, src_ep, dst_ep, radius, tx_options, frame_ctrl;
  logic [7:0]  seq_num, cmd_id, got[$], cyc = 8'h00;
  logic [3:0]  cmd_kind;
  logic [15:0] dst16, cluster_id, profile_id, first_attr;
  logic [63:0] dst64;
  int          failures = 0, check_count = 0, dn = 0, gd = 0, st = 0, refused = 0, i;
  // One command per row, general except the last; ids and radii sit on their edges
  localparam etfb_row_s ROWS [9] = '{
    '{8'h01, 8'h00, 8'h00, 8'h00, etfb_pkg::KIND_READ},
    '{8'h00, 8'h05, 8'h00, 8'h01, etfb_pkg::KIND_READ_RSP},
    '{8'h7f, 8'h01, 8'h00, 8'h02, etfb_pkg::KIND_WRITE},
    '{8'h02, 8'hff, 8'h00, 8'h04, etfb_pkg::KIND_WRITE_RSP},
    '{8'h03, 8'h1e, 8'h00, 8'h06, etfb_pkg::KIND_CFG_REPORT},
    '{8'h00, 8'h00, 8'h10, 8'h0a, etfb_pkg::KIND_REPORT},
    '{8'h04, 8'h02, 8'h08, 8'h0c, etfb_pkg::KIND_DISCOVER},
    '{8'hff, 8'h03, 8'h00, 8'h0d, etfb_pkg::KIND_DISC_RSP},
    '{8'h05, 8'h04, 8'h01, 8'h00, etfb_pkg::KIND_OTHER}};
  etfb_host etfb_host_i (.ref_clk(ref_clk), .rx_ready(rx_ready), .rx_byte(rx_byte),
    .rx_valid(rx_valid));
  etfb_frame_parser etfb_frame_parser_i (.ref_clk(ref_clk), .rst(rst), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .pay_data(pay_data), .pay_valid(pay_valid),
    .pay_ready(pay_ready), .frame_done(frame_done), .frame_good(frame_good),
    .status_wanted(status_wanted), .frame_id(frame_id), .dst64(dst64), .dst16(dst16),
    .src_ep(src_ep), .dst_ep(dst_ep), .cluster_id(cluster_id), .profile_id(profile_id),
    .radius(radius), .tx_options(tx_options), .frame_ctrl(frame_ctrl), .seq_num(seq_num),
    .cmd_id(cmd_id), .cmd_kind(cmd_kind), .first_attr(first_attr));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Stalling receiver takes one word in eight, so the buffer must fill
  always @(negedge ref_clk) begin
    cyc <= cyc + 8'h01;
    pay_ready <= !stall || cyc[2:0] == 3'h0;
  end
  // Tally pulses, refusals while stalling and delivered payload at each sampling edge
  always @(posedge ref_clk) begin
    if (pay_valid && pay_ready) got.push_back(pay_data);
    if (stall && rx_valid && !rx_ready) refused++;
    dn += frame_done;
    gd += frame_good;
    st += status_wanted;
  end
  task automatic ck(input string what, input logic [63:0] seen, exp_v);
    check_count++;
    if (seen !== exp_v) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp_v, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Send one frame, or two back to back, then judge pulses and payload, and fields when bad is zero
  task automatic run(input etfb_row_s r, input logic [7:0] seq, input logic [1:0] bad,
                     input logic chain);
    int d0 = dn;
    int g0 = gd;
    int s0 = st;
    int n = 0;
    int k = chain ? 2 : 1;
    logic [7:0] pay [5] = '{r.ctrl, seq, r.cmd, 8'h03, 8'h00};
    got.delete();
    if (chain) etfb_host_i.send(r.id, r.rad, r.ctrl, seq, r.cmd, 2'h0, 1'b1);
    etfb_host_i.send(r.id, r.rad, r.ctrl, seq, r.cmd, bad, 1'b0);
    while ((dn - d0 < k || got.size() < 5 * k) && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    if (dn - d0 < k || got.size() < 5 * k || etfb_host_i.timed_out) begin
      failures++;
      close_out();
    end
    repeat (3) @(negedge ref_clk);
    ck("done", dn - d0, k);
    ck("good", gd - g0, k - (bad != 2'h0));
    ck("status", st - s0, (r.id != 8'h00 && bad == 2'h0) ? k : 0);
    for (int j = 0; j < 5 * k; j++) ck("payload", got[j], pay[j % 5]);
    if (bad == 2'h0) begin
      ck("frame_id", frame_id, r.id);
      ck("frame_ctrl", frame_ctrl, r.ctrl);
      ck("cmd_id", cmd_id, r.cmd);
      ck("dst64", dst64, etfb_host_i.A64 ^ {8{seq}});
      ck("dst16", dst16, etfb_host_i.A16);
      ck("src_ep", src_ep, 8'h41 ^ seq);
      ck("dst_ep", dst_ep, 8'h42 ^ seq);
      ck("cluster", cluster_id, etfb_host_i.CL ^ {8'h00, seq});
      ck("profile", profile_id, etfb_host_i.PR);
      ck("radius", radius, r.rad == 8'h00 ? etfb_pkg::MAX_HOPS_DFLT : r.rad);
      ck("options", tx_options, 8'h00);
      ck("seq", seq_num, seq);
      ck("kind", cmd_kind, r.kind);
      ck("attr", first_attr, 16'h0003);
    end
  endtask
  // Reset, table rows, then corrupt, stray, empty, stalled and interrupted frames
  initial begin
    repeat (4) @(negedge ref_clk);
    ck("ready_rst", rx_ready, 1'b0);
    rst = 1'b0;
    @(posedge ref_clk);
    #1 ck("ready_up", rx_ready, 1'b1);
    for (i = 0; i < 9; i++) run(ROWS[i], 8'h10 + 8'(i), 2'h0, 1'b0);
    run(ROWS[0], 8'h20, 2'h1, 1'b0);
    run(ROWS[1], 8'h24, 2'h2, 1'b0);
    i = dn;
    etfb_host_i.put(8'h55);
    etfb_host_i.put(8'h7e);
    etfb_host_i.put(8'h00);
    etfb_host_i.put(8'h00);
    repeat (3) @(negedge ref_clk);
    ck("stray", dn - i, 0);
    run(ROWS[6], 8'h21, 2'h0, 1'b1);
    stall = 1'b1;
    run(ROWS[3], 8'h22, 2'h0, 1'b1);
    ck("refused", refused > 0, 1'b1);
    stall = 1'b0;
    etfb_host_i.put(8'h7e);
    etfb_host_i.put(8'h00);
    etfb_host_i.idle();
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    ck("ready_rst2", rx_ready, 1'b0);
    ck("id_rst", frame_id, 8'h00);
    rst = 1'b0;
    run(ROWS[8], 8'h23, 2'h0, 1'b0);
    close_out();
  end
endmodule
